// ---- hdl/transceiver_mode_controller.sv ----
// Function
// R1: reset lands in standby state 60
// R2: low config select forces state 1
// R3: config select plus enable/mode bits pick mode
// R4: stay in state 1, SPI slave, no radio
// R5: config mode keeps receiver/transmitter power state
// R6: state 30 passes MOSI to modulator
// R7: power amplifier off without PLL lock
// R8: receive holds transmitter off; four flows
// R9: wake pin high enters running state directly
// R10: state 0 receiver off, off counter runs
// R11: state 0b on while pin or counter
// R12: state 5 standby, pin high gives 5b
// R13: state 11 identifier match to 12, else 10
// R14: state 12 header timeout 256 bits
// R15: states 13/23 stream data, invert on complement
// R16: pad stream to multiple of eight bits
// R17: oscillator flow: pin low forces state 10
// R18: state 20 standby, 21 waits identifier
// R19: state 22 header match to 23
// R20: pin flow: pin low forces state 20
// R21: monitor enable picks standby or monitor
// R22: standby left only through configuration
// R23: on time is N times 512 clocks
// R24: off time from eight-entry period table
// R25: pins synchronised before use
// R26: host supplies coded transmit stream
`timescale 1ns/10ps
`default_nettype none

module transceiver_mode_controller (
  // clocks and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic linkClk,
  // host pins
  input wire logic configSelectN,
  input wire logic receiverWakePin,
  input wire logic receiverWakeDriven,
  input wire logic mosiIn,
  output logic mosiOut,
  output logic mosiOeN,
  output logic sclkOut,
  output logic sclkOeN,
  // configuration bits
  input wire logic transceiverEnable,
  input wire logic modeSelect,
  input wire logic dataManagerEnable,
  input wire logic oscWakeEnable,
  input wire logic undervoltageMonitorEnable,
  input wire logic [3:0] rxOnCount,
  input wire logic [2:0] rxOffCount,
  // radio and data manager, clk side
  input wire logic pllLocked,
  input wire logic oscTick,
  input wire logic rawRxData,
  input wire logic idMatch,
  input wire logic headerMatch,
  input wire logic headerCompMatch,
  // data manager, link side
  input wire logic rxData,
  input wire logic endOfMessage,
  // status
  output trx_mode_pkg::ctl_state_type ctlState,
  output logic receiverOn,
  output logic transmitterOn,
  output logic paEnable,
  output logic modulatorData,
  output logic oscRunning,
  output logic undervoltageMonitor,
  output logic spiSlaveActive
);

  // ----------------------------------------
  // state and decoded inputs
  // ----------------------------------------
  trx_mode_pkg::main_state_type m, n;
  trx_mode_pkg::link_state_type l, k;
  logic cfgHigh, wakeHigh, wakeLow, oscEdge, onDone, offDone;
  logic doneEv, toEv;
  logic [1:0] flow;
  logic [trx_mode_pkg::ON_CNT_W-1:0] onLoad;
  logic [trx_mode_pkg::OFF_CNT_W-1:0] offLoad;

  // only second-stage samples are used
  assign cfgHigh = m.syncB[trx_mode_pkg::SY_CFG]; // R25
  assign wakeHigh = m.syncB[trx_mode_pkg::SY_WPIN];
  assign wakeLow = m.syncB[trx_mode_pkg::SY_WDRV] & ~m.syncB[trx_mode_pkg::SY_WPIN];
  assign oscEdge = m.syncB[trx_mode_pkg::SY_OSC] & ~m.oscPrev;
  assign onDone = (m.onCnt == '0);
  assign offDone = (m.offCnt == '0);
  assign doneEv = m.doneSy[2] ^ m.doneSy[1];
  assign toEv = m.toSy[2] ^ m.toSy[1];
  assign flow = {dataManagerEnable, oscWakeEnable}; // R8

  // zero on count is forbidden; treat it as one unit
  assign onLoad = trx_mode_pkg::ON_CNT_W'(((rxOnCount == '0) ? 4'h1 : rxOnCount)
                  * trx_mode_pkg::ON_UNIT_CYCLES); // R23
  assign offLoad = trx_mode_pkg::OFF_PERIODS[rxOffCount]; // R24

  // ----------------------------------------
  // controller, clk domain
  // ----------------------------------------
  always_comb begin
    n = m;
    n.syncA = {oscTick, pllLocked, rawRxData, mosiIn,
               receiverWakeDriven, receiverWakePin, configSelectN}; // R25
    n.syncB = m.syncA;
    n.oscPrev = m.syncB[trx_mode_pkg::SY_OSC];
    n.doneSy = {m.doneSy[1:0], l.doneTog};
    n.toSy = {m.toSy[1:0], l.toTog};
    if (!onDone) begin
      n.onCnt = m.onCnt - 1'b1;
    end
    if (oscEdge && !offDone) begin
      n.offCnt = m.offCnt - 1'b1; // R10
    end
    case (m.st)
      trx_mode_pkg::ST_STANDBY, trx_mode_pkg::ST_TX: begin
        n.st = m.st; // R22
      end
      trx_mode_pkg::ST_CONFIG: begin
        if (cfgHigh) begin
          if (!transceiverEnable) begin
            n.st = trx_mode_pkg::ST_STANDBY; // R3 R21
          end else if (modeSelect) begin
            n.st = trx_mode_pkg::ST_TX; // R6
          end else begin
            case (flow)
              2'h0: n.st = wakeHigh ? trx_mode_pkg::ST_ON5B : trx_mode_pkg::ST_MON5; // R9
              2'h1: n.st = wakeHigh ? trx_mode_pkg::ST_ON0B : trx_mode_pkg::ST_OFF0;
              2'h2: n.st = wakeHigh ? trx_mode_pkg::ST_ID21 : trx_mode_pkg::ST_MON20;
              default: n.st = wakeHigh ? trx_mode_pkg::ST_ID11 : trx_mode_pkg::ST_OFF10;
            endcase
            n.onCnt = onLoad;
            n.offCnt = offLoad;
          end
        end
      end
      trx_mode_pkg::ST_OFF0, trx_mode_pkg::ST_OFF10: begin
        // a driven-low pin parks the receiver off
        if (!wakeLow && (wakeHigh || offDone)) begin // R10
          n.st = (m.st == trx_mode_pkg::ST_OFF0) ? trx_mode_pkg::ST_ON0B
                                                  : trx_mode_pkg::ST_ID11;
          n.onCnt = onLoad;
        end
      end
      trx_mode_pkg::ST_ON0B: begin
        if (!wakeHigh && onDone) begin // R11
          n.st = trx_mode_pkg::ST_OFF0;
          n.offCnt = offLoad;
        end
      end
      trx_mode_pkg::ST_MON5: begin
        if (wakeHigh) begin
          n.st = trx_mode_pkg::ST_ON5B; // R12
        end
      end
      trx_mode_pkg::ST_ON5B: begin
        if (!wakeHigh) begin
          n.st = trx_mode_pkg::ST_MON5;
        end
      end
      trx_mode_pkg::ST_ID11: begin
        if (idMatch) begin
          n.st = trx_mode_pkg::ST_HDR12; // R13
        end else if (onDone && !wakeHigh) begin
          n.st = trx_mode_pkg::ST_OFF10;
          n.offCnt = offLoad;
        end
      end
      trx_mode_pkg::ST_HDR12: begin
        if (headerMatch || headerCompMatch) begin
          n.st = trx_mode_pkg::ST_DATA13;
          n.invert = headerCompMatch; // R15
        end else if (toEv) begin
          n.st = trx_mode_pkg::ST_OFF10; // R14
          n.offCnt = offLoad;
        end
      end
      trx_mode_pkg::ST_DATA13: begin
        if (doneEv) begin
          n.st = trx_mode_pkg::ST_OFF10;
          n.offCnt = offLoad;
        end
      end
      trx_mode_pkg::ST_MON20: begin
        if (wakeHigh) begin
          n.st = trx_mode_pkg::ST_ID21; // R18
        end
      end
      trx_mode_pkg::ST_ID21: begin
        if (idMatch) begin
          n.st = trx_mode_pkg::ST_HDR22; // R18
        end
      end
      trx_mode_pkg::ST_HDR22: begin
        if (headerMatch || headerCompMatch) begin
          n.st = trx_mode_pkg::ST_DATA23; // R19
          n.invert = headerCompMatch;
        end
      end
      trx_mode_pkg::ST_DATA23: begin
        if (doneEv) begin
          n.st = trx_mode_pkg::ST_ID21;
        end
      end
      default: n.st = trx_mode_pkg::ST_STANDBY;
    endcase
    // pin overrides for the data-manager flows
    if (wakeLow && m.st inside {trx_mode_pkg::ST_ID11, trx_mode_pkg::ST_HDR12,
                                trx_mode_pkg::ST_DATA13}) begin
      n.st = trx_mode_pkg::ST_OFF10; // R17
      n.offCnt = offLoad;
    end
    if (!wakeHigh && m.st inside {trx_mode_pkg::ST_ID21, trx_mode_pkg::ST_HDR22,
                                  trx_mode_pkg::ST_DATA23}) begin
      n.st = trx_mode_pkg::ST_MON20; // R20
    end
    if (!cfgHigh) begin
      n.st = trx_mode_pkg::ST_CONFIG; // R2 R4
    end
    // receiver and transmitter enables follow state; config keeps the old ones
    if (n.st != trx_mode_pkg::ST_CONFIG) begin // R5
      n.rxOn = n.st inside {trx_mode_pkg::ST_ON0B, trx_mode_pkg::ST_ON5B,
                            trx_mode_pkg::ST_ID11, trx_mode_pkg::ST_HDR12,
                            trx_mode_pkg::ST_DATA13, trx_mode_pkg::ST_ID21,
                            trx_mode_pkg::ST_HDR22, trx_mode_pkg::ST_DATA23};
      n.txOn = (n.st == trx_mode_pkg::ST_TX); // R8
    end
    n.paOn = (n.st == trx_mode_pkg::ST_TX) && m.syncB[trx_mode_pkg::SY_PLL]; // R7
    n.modData = (m.st == trx_mode_pkg::ST_TX) & m.syncB[trx_mode_pkg::SY_MOSI]; // R6
    n.rawOut = m.syncB[trx_mode_pkg::SY_RAW];
    n.rawDrv = n.st inside {trx_mode_pkg::ST_ON0B, trx_mode_pkg::ST_ON5B}; // R11 R12
    n.strmReq = n.st inside {trx_mode_pkg::ST_DATA13, trx_mode_pkg::ST_DATA23};
    n.hdrReq = (n.st == trx_mode_pkg::ST_HDR12);
  end

  // synchronous reset into standby
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      m <= trx_mode_pkg::MAIN_RST; // R1
    end else begin
      m <= n;
    end
  end

  // ----------------------------------------
  // stream and timeout, link domain
  // ----------------------------------------
  // link clock runs at twice the bit rate: one phase sets data, one raises the clock
  always_comb begin
    k = l;
    k.rstSy = {l.rstSy[0], sys_rst};
    k.syA = {m.invert, m.hdrReq, m.strmReq};
    k.syB = l.syA;
    if (!l.syB[trx_mode_pkg::LK_HDR]) begin
      k.toCnt = '0;
      k.toFired = 1'b0;
    end else if (!l.toFired) begin
      if (l.toCnt == trx_mode_pkg::TIMEOUT_LAST) begin
        k.toTog = ~l.toTog; // R14
        k.toFired = 1'b1;
      end else begin
        k.toCnt = l.toCnt + 1'b1;
      end
    end
    if (!l.syB[trx_mode_pkg::LK_STRM]) begin
      k.phase = 1'b0;
      k.bitCnt = '0;
      k.eomSeen = 1'b0;
      k.active = 1'b0;
      k.finished = 1'b0;
      k.sclk = 1'b0;
      k.data = 1'b0;
    end else if (!l.finished) begin
      k.active = 1'b1;
      if (!l.phase) begin
        k.sclk = 1'b0;
        k.eomSeen = l.eomSeen | endOfMessage;
        if ((l.eomSeen | endOfMessage) && l.bitCnt == '0) begin
          k.finished = 1'b1; // R16
          k.active = 1'b0;
          k.doneTog = ~l.doneTog;
        end else begin
          k.phase = 1'b1;
          k.data = (l.eomSeen | endOfMessage) ? trx_mode_pkg::PAD_BIT // R16
                   : rxData ^ l.syB[trx_mode_pkg::LK_INV]; // R15
        end
      end else begin
        k.sclk = 1'b1;
        k.phase = 1'b0;
        k.bitCnt = l.bitCnt + 1'b1;
      end
    end
    // reset reaches this domain through its own two-stage synchroniser
    if (l.rstSy[1]) begin
      k = trx_mode_pkg::LINK_RST;
      k.rstSy = {l.rstSy[0], sys_rst};
    end
  end

  always_ff @(posedge linkClk) begin
    l <= k;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign ctlState = m.st;
  assign receiverOn = m.rxOn;
  assign transmitterOn = m.txOn;
  assign paEnable = m.paOn;
  assign modulatorData = m.modData;
  assign oscRunning = m.st inside {trx_mode_pkg::ST_OFF0, trx_mode_pkg::ST_ON0B,
                                   trx_mode_pkg::ST_OFF10, trx_mode_pkg::ST_ID11,
                                   trx_mode_pkg::ST_HDR12, trx_mode_pkg::ST_DATA13};
  assign undervoltageMonitor = undervoltageMonitorEnable
                               && (m.st inside {trx_mode_pkg::ST_MON5,
                                                trx_mode_pkg::ST_MON20}); // R21
  assign spiSlaveActive = (m.st == trx_mode_pkg::ST_CONFIG); // R4
  // pins are driven only in raw-output or streaming states
  assign mosiOut = l.active ? l.data : m.rawOut;
  assign mosiOeN = ~(m.rawDrv | l.active);
  assign sclkOut = l.sclk;
  assign sclkOeN = ~l.active;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_cfg_low;
    !configSelectN [*3];
  endsequence

  sequence s_leave_cfg_awake;
    m.st == trx_mode_pkg::ST_CONFIG && cfgHigh && transceiverEnable
      && !modeSelect && wakeHigh;
  endsequence

  property p_reset;
    @(posedge clk) sys_rst |=> ctlState == trx_mode_pkg::ST_STANDBY;
  endproperty
  a_reset: assert property (p_reset) else $error("reset not in standby"); // R1

  property p_cfg;
    @(posedge clk) disable iff (sys_rst)
      s_cfg_low |=> ctlState == trx_mode_pkg::ST_CONFIG;
  endproperty
  a_cfg: assert property (p_cfg) else $error("config select ignored"); // R2

  property p_cfg_quiet;
    @(posedge clk) disable iff (sys_rst)
      spiSlaveActive |-> mosiOeN && !paEnable;
  endproperty
  a_cfg_quiet: assert property (p_cfg_quiet) else $error("radio active in config"); // R4

  property p_cfg_hold;
    @(posedge clk) disable iff (sys_rst)
      (m.st == trx_mode_pkg::ST_CONFIG) && !cfgHigh
      |=> $stable(receiverOn) && $stable(transmitterOn);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("config changed power"); // R5

  property p_pa;
    @(posedge clk) disable iff (sys_rst)
      paEnable |-> transmitterOn && $past(m.syncB[trx_mode_pkg::SY_PLL]);
  endproperty
  a_pa: assert property (p_pa) else $error("amplifier on without lock"); // R7

  property p_rx_no_tx;
    @(posedge clk) disable iff (sys_rst)
      receiverOn |-> !transmitterOn;
  endproperty
  a_rx_no_tx: assert property (p_rx_no_tx) else $error("transmitter on in receive"); // R8

  property p_awake;
    @(posedge clk) disable iff (sys_rst)
      s_leave_cfg_awake |=> receiverOn ##1 1'b1;
  endproperty
  a_awake: assert property (p_awake) else $error("wake pin entry not direct"); // R9

  property p_standby;
    @(posedge clk) disable iff (sys_rst)
      ctlState == trx_mode_pkg::ST_STANDBY && cfgHigh |=> ctlState == trx_mode_pkg::ST_STANDBY;
  endproperty
  a_standby: assert property (p_standby) else $error("standby left"); // R22

  property p_pin_flow;
    @(posedge clk) disable iff (sys_rst)
      cfgHigh && !wakeHigh && (m.st inside {trx_mode_pkg::ST_ID21, trx_mode_pkg::ST_HDR22,
                                            trx_mode_pkg::ST_DATA23})
      |=> ctlState == trx_mode_pkg::ST_MON20;
  endproperty
  a_pin_flow: assert property (p_pin_flow) else $error("pin low not to state 20"); // R20

  property p_on_load;
    @(posedge clk) disable iff (sys_rst)
      (m.st == trx_mode_pkg::ST_OFF10) && (n.st == trx_mode_pkg::ST_ID11)
      |=> m.onCnt == onLoad;
  endproperty
  a_on_load: assert property (p_on_load) else $error("on time wrong"); // R23

  property p_timeout;
    @(posedge linkClk) disable iff (l.rstSy[1])
      $changed(l.toTog) |-> $past(l.toCnt) == trx_mode_pkg::TIMEOUT_LAST;
  endproperty
  a_timeout: assert property (p_timeout) else $error("header timeout count wrong"); // R14

  property p_pad;
    @(posedge linkClk) disable iff (l.rstSy[1])
      $changed(l.doneTog) |-> l.bitCnt == '0 && !l.active;
  endproperty
  a_pad: assert property (p_pad) else $error("stream not byte aligned"); // R16

endmodule : transceiver_mode_controller

`default_nettype wire

// ---- hdl/trx_mode_pkg.sv ----
package trx_mode_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int ON_UNIT_CYCLES = 512;
  localparam int ON_CNT_W = 13;
  localparam int OFF_CNT_W = 6;
  localparam int TIMEOUT_BITS = 256;
  localparam int LINK_CYC_PER_BIT = 2;
  localparam int TO_W = 10;
  localparam logic [TO_W-1:0] TIMEOUT_LAST = TO_W'(TIMEOUT_BITS * LINK_CYC_PER_BIT - 1);
  localparam int BYTE_BITS = 8;
  localparam int BIT_CNT_W = $clog2(BYTE_BITS);
  localparam logic PAD_BIT = 1'b0;

  // off time in wake-oscillator periods, indexed by rx_off_count
  localparam logic [OFF_CNT_W-1:0] OFF_PERIODS [0:7] = '{
    6'h01, 6'h02, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h20, 6'h3f};

  // ----------------------------------------
  // pin synchroniser lanes
  // ----------------------------------------
  localparam int SY_CFG = 0;
  localparam int SY_WPIN = 1;
  localparam int SY_WDRV = 2;
  localparam int SY_MOSI = 3;
  localparam int SY_RAW = 4;
  localparam int SY_PLL = 5;
  localparam int SY_OSC = 6;
  localparam int SY_N = 7;
  localparam logic [SY_N-1:0] SYNC_RST = 7'h01;

  // link-side lanes
  localparam int LK_STRM = 0;
  localparam int LK_HDR = 1;
  localparam int LK_INV = 2;
  localparam int LK_N = 3;

  // ----------------------------------------
  // states
  // ----------------------------------------
  typedef enum logic [3:0] {
    ST_STANDBY, ST_CONFIG, ST_TX,
    ST_OFF0, ST_ON0B, ST_MON5, ST_ON5B,
    ST_OFF10, ST_ID11, ST_HDR12, ST_DATA13,
    ST_MON20, ST_ID21, ST_HDR22, ST_DATA23
  } ctl_state_type;

  typedef struct packed {
    logic [SY_N-1:0] syncA;
    logic [SY_N-1:0] syncB;
    logic oscPrev;
    ctl_state_type st;
    logic rxOn;
    logic txOn;
    logic paOn;
    logic [ON_CNT_W-1:0] onCnt;
    logic [OFF_CNT_W-1:0] offCnt;
    logic invert;
    logic strmReq;
    logic hdrReq;
    logic rawDrv;
    logic rawOut;
    logic modData;
    logic [2:0] doneSy;
    logic [2:0] toSy;
  } main_state_type;

  localparam main_state_type MAIN_RST = '{
    syncA: SYNC_RST, syncB: SYNC_RST, st: ST_STANDBY, default: '0};

  typedef struct packed {
    logic [1:0] rstSy;
    logic [LK_N-1:0] syA;
    logic [LK_N-1:0] syB;
    logic phase;
    logic [BIT_CNT_W-1:0] bitCnt;
    logic eomSeen;
    logic active;
    logic finished;
    logic doneTog;
    logic [TO_W-1:0] toCnt;
    logic toFired;
    logic toTog;
    logic data;
    logic sclk;
  } link_state_type;

  localparam link_state_type LINK_RST = '{rstSy: 2'h3, default: '0};

endpackage : trx_mode_pkg

// ---- test/link_source.sv ----
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// data manager stream source
// ----------------------------------------
module link_source #(
  parameter logic [7:0] PATTERN = 8'hb3
) (
  // link side
  input wire logic linkClk,
  input wire logic sclkOut,
  input wire logic sclkOeN,
  input wire logic mosiOut,
  output logic rxData,
  output logic endOfMessage,
  // bench side
  input wire logic [3:0] msgBits,
  output logic [3:0] rises,
  output logic firstBit
);
  logic [3:0] sent = 4'h0;
  logic sclkPrev = 1'b0;

  // works mid-cycle so the device's phase-0 edge always sees a settled bit
  always @(negedge linkClk) begin
    sclkPrev <= sclkOut;
    if (sclkOeN) begin
      sent <= 4'h0;
      endOfMessage <= 1'b0;
    end else if (sclkOut && !sclkPrev) begin
      if (sent == 4'h0) begin
        firstBit <= mosiOut;
      end
      rises <= (sent == 4'h0) ? 4'h1 : rises + 4'h1;
      sent <= sent + 4'h1;
      endOfMessage <= (sent + 4'h1 >= msgBits);
    end
  end

  // next message bit, advanced once per shifted bit
  assign rxData = PATTERN[sent[2:0]];
endmodule : link_source
`default_nettype wire

// ---- test/tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  // ----------------------------------------
  // stimulus and wiring
  // ----------------------------------------
  logic clk = 1'b0;
  logic linkClk = 1'b0;
  logic sys_rst = 1'b1;
  logic configSelectN = 1'b1;
  logic receiverWakePin = 1'b0;
  logic receiverWakeDriven = 1'b1;
  logic mosiIn = 1'b0;
  logic transceiverEnable = 1'b0;
  logic modeSelect = 1'b0;
  logic dataManagerEnable = 1'b0;
  logic oscWakeEnable = 1'b0;
  logic undervoltageMonitorEnable = 1'b0;
  logic [3:0] rxOnCount = 4'h1;
  logic [2:0] rxOffCount = 3'h2;
  logic pllLocked = 1'b0;
  logic oscTick = 1'b0;
  logic rawRxData = 1'b0;
  logic idMatch = 1'b0;
  logic headerMatch = 1'b0;
  logic headerCompMatch = 1'b0;
  logic rxData, endOfMessage, mosiOut, mosiOeN, sclkOut, sclkOeN;
  logic receiverOn, transmitterOn, paEnable, modulatorData;
  logic oscRunning, undervoltageMonitor, spiSlaveActive, firstBit;
  logic [3:0] msgBits = 4'h8;
  logic [3:0] rises;
  logic [7:0] rnd = 8'h52;
  logic [3:0] hist = 4'h0;
  logic [3:0] phist = 4'h0;
  trx_mode_pkg::ctl_state_type ctlState;
  int badCount = 0;
  int checkCount = 0;

  always #25 clk = ~clk;
  // link clock, phase unrelated to clk
  initial begin
    #13;
    forever #40 linkClk = ~linkClk;
  end

  transceiver_mode_controller u_dut (.clk(clk), .sys_rst(sys_rst), .linkClk(linkClk),
    .configSelectN(configSelectN), .receiverWakePin(receiverWakePin),
    .receiverWakeDriven(receiverWakeDriven), .mosiIn(mosiIn), .mosiOut(mosiOut),
    .mosiOeN(mosiOeN), .sclkOut(sclkOut), .sclkOeN(sclkOeN),
    .transceiverEnable(transceiverEnable), .modeSelect(modeSelect),
    .dataManagerEnable(dataManagerEnable), .oscWakeEnable(oscWakeEnable),
    .undervoltageMonitorEnable(undervoltageMonitorEnable), .rxOnCount(rxOnCount),
    .rxOffCount(rxOffCount), .pllLocked(pllLocked), .oscTick(oscTick),
    .rawRxData(rawRxData), .idMatch(idMatch), .headerMatch(headerMatch),
    .headerCompMatch(headerCompMatch), .rxData(rxData), .endOfMessage(endOfMessage),
    .ctlState(ctlState), .receiverOn(receiverOn), .transmitterOn(transmitterOn),
    .paEnable(paEnable), .modulatorData(modulatorData), .oscRunning(oscRunning),
    .undervoltageMonitor(undervoltageMonitor), .spiSlaveActive(spiSlaveActive));

  link_source u_src (.linkClk(linkClk), .sclkOut(sclkOut), .sclkOeN(sclkOeN),
    .mosiOut(mosiOut), .rxData(rxData), .endOfMessage(endOfMessage),
    .msgBits(msgBits), .rises(rises), .firstBit(firstBit));

  // ----------------------------------------
  // expectations and checks
  // ----------------------------------------
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_next

  // state reached on leaving config with the pin driven
  function automatic trx_mode_pkg::ctl_state_type exp_rx(input logic data_manager_enable, osc, wake);
    case ({data_manager_enable, osc})
      2'b00: return wake ? trx_mode_pkg::ST_ON5B : trx_mode_pkg::ST_MON5;
      2'b01: return wake ? trx_mode_pkg::ST_ON0B : trx_mode_pkg::ST_OFF0;
      2'b10: return wake ? trx_mode_pkg::ST_ID21 : trx_mode_pkg::ST_MON20;
      default: return wake ? trx_mode_pkg::ST_ID11 : trx_mode_pkg::ST_OFF10;
    endcase
  endfunction : exp_rx

  task automatic finishTest();
    $display("checks %0d mismatches %0d", checkCount, badCount);
    if (badCount == 0 && checkCount > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finishTest

  task automatic chk_bit(input string what, input logic expV, input logic seenV);
    checkCount++;
    if (seenV !== expV) begin
      badCount++;
      $display("Error %s expected %b seen %b", what, expV, seenV);
    end
  endtask : chk_bit

  task automatic chk_state(input trx_mode_pkg::ctl_state_type expS);
    checkCount++;
    if (ctlState !== expS) begin
      badCount++;
      $display("Error ctlState expected %s seen %s", expS.name(), ctlState.name());
    end
  endtask : chk_state

  task automatic chk_cnt(input string what, input logic [3:0] expV, input logic [3:0] seenV);
    checkCount++;
    if (seenV !== expV) begin
      badCount++;
      $display("Error %s expected %0d seen %0d", what, expV, seenV);
    end
  endtask : chk_cnt

  // bounded wait; running out ends the run
  task automatic wait_state(input trx_mode_pkg::ctl_state_type expS, input int maxCyc);
    int n;
    n = 0;
    while (ctlState !== expS && n < maxCyc) begin
      @(negedge clk);
      n++;
    end
    chk_state(expS);
    if (n >= maxCyc) begin
      finishTest();
    end
  endtask : wait_state

  task automatic to_config();
    @(negedge clk);
    configSelectN = 1'b0;
    wait_state(trx_mode_pkg::ST_CONFIG, 10);
    chk_bit("spiSlaveActive", 1'b1, spiSlaveActive);
  endtask : to_config

  task automatic leave(input logic transceiver_enable, mode, data_manager_enable, osc);
    transceiverEnable = transceiver_enable;
    modeSelect = mode;
    dataManagerEnable = data_manager_enable;
    oscWakeEnable = osc;
    @(negedge clk);
    configSelectN = 1'b1;
  endtask : leave

  task automatic pulse(ref logic sig, input int len);
    sig = 1'b1;
    repeat (len) @(negedge clk);
    sig = 1'b0;
    repeat (len) @(negedge clk);
  endtask : pulse

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
    chk_state(trx_mode_pkg::ST_STANDBY);
    chk_bit("mosiOeN", 1'b1, mosiOeN);
    // standby ignores everything but config select
    receiverWakePin = 1'b1;
    transceiverEnable = 1'b1;
    repeat (10) @(negedge clk);
    chk_state(trx_mode_pkg::ST_STANDBY);
    receiverWakePin = 1'b0;
    to_config();
    leave(1'b1, 1'b1, 1'b0, 1'b0);
    wait_state(trx_mode_pkg::ST_TX, 10);
    chk_bit("transmitterOn", 1'b1, transmitterOn);
    // random host bits and lock flicker, both seen three clocks later
    for (int i = 0; i < 40; i++) begin
      @(negedge clk);
      rnd = lfsr_next(rnd);
      hist = {hist[2:0], rnd[0]};
      phist = {phist[2:0], rnd[1]};
      mosiIn = rnd[0];
      pllLocked = rnd[1];
      if (i > 3) begin
        chk_bit("modulatorData", hist[3], modulatorData);
        chk_bit("paEnable", phist[3], paEnable);
      end
    end
    to_config();
    chk_bit("transmitterOn", 1'b1, transmitterOn);
    leave(1'b0, 1'b0, 1'b0, 1'b0);
    wait_state(trx_mode_pkg::ST_STANDBY, 10);
    to_config();
    // every receive flow with the pin high and low
    for (int f = 0; f < 8; f++) begin
      rnd = lfsr_next(rnd);
      receiverWakePin = f[2];
      undervoltageMonitorEnable = rnd[2];
      leave(1'b1, 1'b0, f[1], f[0]);
      wait_state(exp_rx(f[1], f[0], f[2]), 10);
      chk_bit("transmitterOn", 1'b0, transmitterOn);
      chk_bit("receiverOn", f[2], receiverOn);
      chk_bit("undervoltageMonitor", rnd[2] & !f[0] & !f[2], undervoltageMonitor);
      if (f[2] && !f[1]) begin
        for (int j = 0; j < 4; j++) begin
          rawRxData = rnd[j];
          repeat (4) @(negedge clk);
          chk_bit("mosiOut", rnd[j], mosiOut);
        end
      end
      if (f[2] && f[1]) begin
        receiverWakePin = 1'b0;
        wait_state(f[0] ? trx_mode_pkg::ST_OFF10 : trx_mode_pkg::ST_MON20, 10);
      end
      to_config();
      chk_bit("receiverOn", f[2] && !f[1], receiverOn);
    end
    // streamed message, plain header then complement with a short message
    for (int k = 0; k < 2; k++) begin
      receiverWakePin = 1'b1;
      msgBits = k ? 4'h5 : 4'h8;
      leave(1'b1, 1'b0, 1'b1, 1'b0);
      wait_state(trx_mode_pkg::ST_ID21, 10);
      pulse(idMatch, 1);
      wait_state(trx_mode_pkg::ST_HDR22, 10);
      repeat (20) @(negedge clk);
      chk_state(trx_mode_pkg::ST_HDR22);
      if (k) pulse(headerCompMatch, 1);
      else pulse(headerMatch, 1);
      wait_state(trx_mode_pkg::ST_DATA23, 10);
      wait_state(trx_mode_pkg::ST_ID21, 2000);
      chk_cnt("streamBits", 4'h8, rises);
      chk_bit("firstBit", 1'b1 ^ k[0], firstBit);
      to_config();
    end
    // oscillator flow with the pin left floating
    receiverWakeDriven = 1'b0;
    receiverWakePin = 1'b0;
    leave(1'b1, 1'b0, 1'b1, 1'b1);
    wait_state(trx_mode_pkg::ST_OFF10, 10);
    chk_bit("oscRunning", 1'b1, oscRunning);
    repeat (3) pulse(oscTick, 2);
    chk_state(trx_mode_pkg::ST_OFF10);
    pulse(oscTick, 2);
    wait_state(trx_mode_pkg::ST_ID11, 10);
    repeat (495) @(negedge clk);
    chk_state(trx_mode_pkg::ST_ID11);
    wait_state(trx_mode_pkg::ST_OFF10, 40);
    repeat (4) pulse(oscTick, 2);
    wait_state(trx_mode_pkg::ST_ID11, 10);
    pulse(idMatch, 1);
    wait_state(trx_mode_pkg::ST_HDR12, 10);
    repeat (700) @(negedge clk);
    chk_state(trx_mode_pkg::ST_HDR12);
    wait_state(trx_mode_pkg::ST_OFF10, 300);
    finishTest();
  end
endmodule : tb_top
`default_nettype wire
